// *** bench/fesr_chk_props.sv ***
// Concurrent checks on the ports of the flash error status block
`timescale 1ns/1ps
module fesr_chk
	import fesr_pkg::*;
#(
	parameter int BUSY_CYC = PROT_BUSY_CYC
)
(
	input wire logic          clk,
	input wire logic          rst_n,
	input wire logic          ce,
	input wire logic          cmd_valid,
	input fesr_cmd_t          cmd,
	input fesr_ecc_evt_t      ecc_evt,
	input wire logic          int_en,
	input wire logic          rd_active,
	input wire logic          rd_is_status,
	input wire logic [SR_W-1:0] status_word_r,
	input fesr_eac_t          eac_state_r,
	input wire logic          busy_r,
	input wire logic          cmd_accept_r,
	input wire logic          cmd_ignored_r,
	input wire logic          data_indet_r,
	input wire logic          int_n
);
	// Margin covers the timer start and the done pulse
	localparam int PMAX = BUSY_CYC + 4;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	busy_ignore_a: assert property (
		ce && cmd_valid && eac_state_r == EAC_BUSY && cmd != CMD_STATUS_READ |=> cmd_ignored_r)
		else $error("command taken while busy");
	err_status_a: assert property (
		eac_state_r == EAC_ERR_HOLD |-> status_word_r[7] && !status_word_r[2] && !status_word_r[1])
		else $error("bad status in error hold");
	err_refuse_a: assert property (
		ce && cmd_valid && eac_state_r == EAC_ERR_HOLD
		&& !(cmd inside {CMD_STATUS_READ, CMD_RESET, CMD_STATUS_CLEAR}) |=> cmd_ignored_r)
		else $error("command taken in error hold");
	prot_busy_a: assert property (
		eac_state_r == EAC_PROT_BUSY |-> !status_word_r[7] && busy_r)
		else $error("ready during protection busy");
	prot_len_a: assert property (
		$rose(eac_state_r == EAC_PROT_BUSY) |-> ##[1:PMAX] eac_state_r != EAC_PROT_BUSY)
		else $error("protection busy too long");
	prot_end_a: assert property (
		$fell(eac_state_r == EAC_PROT_BUSY) |-> status_word_r[7] && status_word_r[1])
		else $error("bad status after protection busy");
	wba_status_a: assert property (
		eac_state_r == EAC_WBA_HOLD |-> (status_word_r & 8'hBE) == 8'h98 && busy_r)
		else $error("bad status in buffer abort");
	clear_bits_a: assert property (
		ce && cmd_valid && cmd == CMD_STATUS_CLEAR && eac_state_r == EAC_ERR_HOLD
		|=> status_word_r[5:1] == 5'h00 && cmd_accept_r)
		else $error("status clear left flags");
	int_pulse_a: assert property (
		ce && int_en && ecc_evt.hp_valid && (ecc_evt.corr || ecc_evt.det) |=> !int_n)
		else $error("no interrupt on ecc event");
	indet_read_a: assert property (
		ce && rd_active && !rd_is_status && eac_state_r != EAC_STANDBY |=> data_indet_r)
		else $error("read data not marked indeterminate");
endmodule

// *** bench/fesr_host.sv ***
// Host bus master model: command issue and strobe idle watchdog
`timescale 1ns/1ps
module fesr_host
	import fesr_pkg::*;
(
	input  wire logic clk,
	input  wire logic rd_active,
	input  wire logic rwds,
	output logic      cmd_valid,
	output fesr_cmd_t cmd,
	output logic      bus_err
);
	int   idle = 0;
	logic last = 1'b0;
	initial
	begin
		cmd_valid = 1'b0;
		cmd = CMD_NONE;
		bus_err = 1'b0;
	end
	// One-cycle strobe; code is dropped once taken so stale codes never linger
	task automatic send(input fesr_cmd_t c);
		@(posedge clk);
		#1 cmd_valid = 1'b1;
		cmd = c;
		@(posedge clk);
		#1 cmd_valid = 1'b0;
		cmd = CMD_NONE;
	endtask
	// Sticky, never cleared by the model; one stall of more than 32 cycles is enough to fail the burst
	always @(posedge clk)
	begin
		idle = (rd_active && rwds == last) ? idle + 1 : 0;
		last = rwds;
		if (idle > 32)
			bus_err = 1'b1;
	end
endmodule

// *** bench/tb_top.sv ***
// Self-checking bench for the flash error status block
`timescale 1ns/1ps
module tb_top
	import fesr_pkg::*;
;
	localparam int BC = 5;
	logic clk = 1'b0, rst_n = 1'b0, op_done = 1'b0, tmo = 1'b0, rd_act = 1'b0, rd_st = 1'b0;
	logic rwds_in = 1'b0, cs_n = 1'b1, int_en = 1'b0, cmd_valid, bus_err;
	logic tog = 1'b0, esusp = 1'b0;
	logic acc, ign, rwds_r, trap_valid, int_n, pflag, indet, busy;
	logic [15:0] cfg = 16'h0004;
	logic [15:0] ecc;
	logic [7:0] sr;
	logic [24:0] addr = '0, trap;
	fesr_cmd_t cmd;
	fesr_op_res_t op_res = '0;
	fesr_ecc_evt_t evt = '0;
	fesr_eac_t st;
	fesr_mode_t mode;
	int n_fail = 0, checked = 0;
	logic [31:0] seed = 32'h0000004B;
	bit exp_q[$];
	fesr_top #(.BUSY_CYC(BC)) uut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .cmd_valid(cmd_valid),
		.cmd(cmd), .op_done(op_done), .op_res(op_res), .timeout_evt(tmo), .erase_susp(esusp),
		.rd_active(rd_act), .rd_is_status(rd_st), .rwds_in(rwds_in), .cs_n_pin(cs_n),
		.ecc_evt(evt), .hp_addr(addr), .config_word(cfg), .int_en(int_en),
		.status_word_r(sr), .eac_state_r(st), .mode_r(mode), .busy_r(busy),
		.cmd_accept_r(acc), .cmd_ignored_r(ign), .polling_timeout_flag_r(pflag),
		.data_indet_r(indet), .rwds_r(rwds_r), .ecc_unit_status(ecc), .trap_addr(trap),
		.trap_valid(trap_valid), .int_n(int_n));
	fesr_host host (.clk(clk), .rd_active(rd_act), .rwds(rwds_r), .cmd_valid(cmd_valid),
		.cmd(cmd), .bus_err(bus_err));
	initial
	begin
		forever #5 clk = ~clk;
	end
	// Strobe toggles during the stalled read so that only a stall can starve the host
	always @(posedge clk)
	begin
		if (tog)
			#1 rwds_in = ~rwds_in;
		else
			#1 rwds_in = 1'b1;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic send(input fesr_cmd_t c, input bit a);
		exp_q.push_back(a);
		host.send(c);
	endtask
	task automatic op(input logic [5:0] r);
		@(posedge clk);
		#1 op_done = 1'b1;
		op_res = r;
		@(posedge clk);
		#1 op_done = 1'b0;
		op_res = '0;
	endtask
	task automatic ev(input logic [5:0] v);
		@(posedge clk);
		#1 evt = v;
		addr = 25'(rnd());
		@(posedge clk);
		#1 evt = '0;
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Every answer pulse is matched against the oldest expectation
	always @(negedge clk)
	begin
		if (acc === 1'b1 || ign === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk(16'h0001, 16'h0000);
			else
				chk(acc, exp_q.pop_front());
		end
	end
	initial
	begin
		#50000;
		n_fail++;
		complete_run();
	end
	initial
	begin
		wait_cyc(2);
		rst_n = 1'b1;
		chk({sr, ecc[7:0]}, 16'h8000);
		tmo = 1'b1;
		wait_cyc(1);
		tmo = 1'b0;
		wait_cyc(1);
		chk(pflag, 1'b1);
		send(CMD_RESET, 1'b1);
		chk({pflag, st}, {1'b0, EAC_STANDBY});
		send(CMD_PROGRAM, 1'b1);
		chk({busy, sr[7]}, 2'h2);
		rd_act = 1'b1;
		wait_cyc(1);
		rd_act = 1'b0;
		chk(indet, 1'b1);
		send(CMD_RESET, 1'b0);
		op(6'h08);
		chk({st, sr[7], sr[5:1]}, {EAC_ERR_HOLD, 6'h28});
		send(CMD_PROGRAM, 1'b0);
		send(CMD_STATUS_READ, 1'b1);
		send(CMD_STATUS_CLEAR, 1'b1);
		chk({st, sr[5:1]}, {EAC_STANDBY, 5'h00});
		send(CMD_ERASE, 1'b1);
		op(6'h20);
		chk(sr[5], 1'b1);
		send(CMD_RESET, 1'b1);
		chk({st, mode}, {EAC_STANDBY, MODE_READ});
		send(CMD_PROGRAM, 1'b1);
		op(6'h09);
		chk({st, sr[7]}, {EAC_PROT_BUSY, 1'b0});
		send(CMD_STATUS_CLEAR, 1'b0);
		wait_cyc(BC + 4);
		chk({st, sr[7], sr[4], sr[1]}, {EAC_STANDBY, 3'h7});
		send(CMD_PROGRAM, 1'b1);
		chk(sr[4], 1'b0);
		op(6'h02);
		chk({st, sr & 8'hBE}, {EAC_WBA_HOLD, 8'h98});
		send(CMD_STATUS_READ, 1'b1);
		chk({st, busy}, {EAC_WBA_HOLD, 1'b1});
		send(CMD_WBA_RESET, 1'b1);
		chk(st, EAC_STANDBY);
		send(CMD_ECC_READ, 1'b0);
		send(CMD_ECC_ENTER, 1'b1);
		chk(mode, MODE_OVERLAY);
		int_en = 1'b1;
		ev(6'h30);
		chk(int_n, 1'b0);
		evt = 6'h02;
		send(CMD_ECC_READ, 1'b1);
		evt = '0;
		chk(ecc[4:0], 5'h0A);
		ev(6'h28);
		chk({trap_valid, ecc[4]}, 2'h3);
		chk(trap, addr);
		send(CMD_RESET, 1'b1);
		chk({trap_valid, ecc}, 17'h00000);
		esusp = 1'b1;
		wait_cyc(1);
		chk({mode, sr[6]}, {MODE_ERASE_SUSP, 1'b1});
		esusp = 1'b0;
		cfg = 16'h0000;
		cs_n = 1'b0;
		tog = 1'b1;
		rd_act = 1'b1;
		wait_cyc(3);
		ev(6'h28);
		wait_cyc(3);
		chk(rwds_r, 1'b0);
		wait_cyc(36);
		chk(bus_err, 1'b1);
		cs_n = 1'b1;
		tog = 1'b0;
		rd_act = 1'b0;
		wait_cyc(5);
		chk(rwds_r, 1'b1);
		wait_cyc(4);
		chk(exp_q.size(), 16'h0000);
		complete_run();
	end
endmodule
bind fesr_top fesr_chk #(.BUSY_CYC(BUSY_CYC)) chk_i (.clk, .rst_n, .ce, .cmd_valid, .cmd,
	.ecc_evt, .int_en, .rd_active, .rd_is_status, .status_word_r, .eac_state_r, .busy_r,
	.cmd_accept_r, .cmd_ignored_r, .data_indet_r, .int_n);

// *** design/fesr_ecc_track.sv ***
// ECC unit status word, sticky global flags, address trap, interrupt and strobe stall
`timescale 1ns/1ps
module fesr_ecc_track
	import fesr_pkg::*;
#(
	parameter int AW = ADDR_W
)
(
	input  wire logic            clk,
	input  wire logic            rst_n,
	input  wire logic            ce,
	input  fesr_ecc_evt_t        evt,
	input  wire logic [AW-1:0]   hp_addr,
	input  wire logic            unit_rd,
	input  wire logic            ovl_exit,
	input  wire logic            cs_low,
	input  wire logic            stall_ctl,
	input  wire logic            int_en,
	output logic [ECC_W-1:0]     status,
	output logic [AW-1:0]        trap_addr,
	output logic                 trap_valid,
	output logic                 stall,
	output logic                 int_n
);

	typedef struct packed {
		logic [2:0]    unit;
		logic          corr;
		logic          det;
		logic [AW-1:0] trap;
		logic          trap_ok;
		logic          stall;
		logic          int_n;
	} fesr_ecc_st_t;

	fesr_ecc_st_t st_r;
	fesr_ecc_st_t st_nxt;

	logic hit_corr;
	logic hit_det;

	always_comb
	begin
		hit_corr = evt.hp_valid & evt.corr;
		hit_det  = evt.hp_valid & evt.det;
		st_nxt = st_r;
		if (ovl_exit)
		begin
			st_nxt.unit    = '0;
			st_nxt.corr    = 1'b0;
			st_nxt.det     = 1'b0;
			st_nxt.trap_ok = 1'b0;
		end
		if (unit_rd)
		begin
			st_nxt.unit = {evt.code_err, evt.data_err, evt.unit_off};
		end
		// Set beats the overlay-exit clear in the same cycle
		if (hit_corr)
		begin
			st_nxt.corr = 1'b1;
		end
		if (hit_det)
		begin
			st_nxt.det = 1'b1;
		end
		// Only the first double detection since the last exit is kept
		if (hit_det && (!st_r.trap_ok || ovl_exit))
		begin
			st_nxt.trap    = hp_addr;
			st_nxt.trap_ok = 1'b1;
		end
		if (!cs_low)
		begin
			st_nxt.stall = 1'b0;
		end
		else if (hit_det && !stall_ctl)
		begin
			st_nxt.stall = 1'b1;
		end
		st_nxt.int_n = ~(int_en & (hit_corr | hit_det));
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st_r       <= '0;
			st_r.int_n <= 1'b1;
		end
		else if (ce)
		begin
			st_r <= st_nxt;
		end
	end

	always_comb
	begin
		status = ECC_RESET;
		status[ECC_OFF]  = st_r.unit[0];
		status[ECC_DATA] = st_r.unit[1];
		status[ECC_CODE] = st_r.unit[2];
		status[ECC_CORR] = st_r.corr;
		status[ECC_DET]  = st_r.det;
	end

	assign trap_addr  = st_r.trap;
	assign trap_valid = st_r.trap_ok;
	assign stall      = st_r.stall;
	assign int_n      = st_r.int_n;

endmodule

// *** design/fesr_prot_timer.sv ***
// Busy period timer for an aborted program or erase on a protected area
`timescale 1ns/1ps
module fesr_prot_timer
	import fesr_pkg::*;
#(
	parameter int CYC = PROT_BUSY_CYC
)
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic start,
	output logic      busy,
	output logic      done
);

	localparam logic [PROT_CNT_W-1:0] LAST = PROT_CNT_W'(CYC - 1);

	fesr_tmr_st_t st_r;
	fesr_tmr_st_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		if (start)
		begin
			st_nxt.run = 1'b1;
			st_nxt.cnt = '0;
		end
		else if (st_r.run)
		begin
			if (st_r.cnt == LAST)
			begin
				st_nxt.run  = 1'b0;
				st_nxt.done = 1'b1;
			end
			else
			begin
				st_nxt.cnt = st_r.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st_r <= '0;
		end
		else if (ce)
		begin
			st_r <= st_nxt;
		end
	end

	assign busy = st_r.run;
	assign done = st_r.done;

endmodule

// *** design/fesr_top.sv ***
// Embedded algorithm error status handling with ECC error reporting
`timescale 1ns/1ps

// Notes on behaviour
// - Software reset returns controller to standby and clears polling timeout flag.
// - Reset commands are ignored while a program or erase is running.
// - Reset keeps algorithm mode and outputs; leaves overlay or failed operation.
// - No wait is needed after a software reset.
// - Clearing errors returns to overlay, else erase suspend, else standby.
// - Operation error keeps controller active, reporting ready, until host clears it.
// - Operation error: bit7 set, bit5 erase/blank, bit4 program/password, bits2,1 clear.
// - During operation error only status read, reset and clear are accepted.
// - Protected target aborts; busy for the set period, bit7 clear, status read only.
// - After protection busy: bits7 and 1 set, 5/4 show failure, all commands ok.
// - New program clears bit4; new erase clears bit6.
// - Buffer abort: busy with bits7,4,3 set and bits5,2,1 clear until cleared.
// - Buffer abort cleared by abort reset or clear; status read keeps it.
// - Non-status reads during an algorithm still toggle the strobe, data indeterminate.
// - Enabled interrupt signals one or two bit ECC errors on half-page reads.
// - ECC status read command with unit address reports that unit's status.
// - Unit bits: 0 correction off, 1 data corrected, 2 check code corrected.
// - Correction and double detect bits are global, sticky since last overlay exit.
// - After double detect bits 3 to 1 are invalid; its address is trapped.
// - Bits 15 to 5 are reserved and to be ignored.
// - ECC status clears on hardware reset and on ECC overlay exit.
// - With stall enabled, double detect holds strobe low until chip select rises.
module fesr_top
	import fesr_pkg::*;
#(
	parameter int AW       = ADDR_W,
	parameter int BUSY_CYC = PROT_BUSY_CYC
)
(
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          ce,
	input  wire logic          cmd_valid,
	input  fesr_cmd_t          cmd,
	input  wire logic          op_done,
	input  fesr_op_res_t       op_res,
	input  wire logic          timeout_evt,
	input  wire logic          erase_susp,
	input  wire logic          rd_active,
	input  wire logic          rd_is_status,
	input  wire logic          rwds_in,
	input  wire logic          cs_n_pin,
	input  fesr_ecc_evt_t      ecc_evt,
	input  wire logic [AW-1:0] hp_addr,
	input  wire logic [15:0]   config_word,
	input  wire logic          int_en,
	output logic [SR_W-1:0]    status_word_r,
	output fesr_eac_t          eac_state_r,
	output fesr_mode_t         mode_r,
	output logic               busy_r,
	output logic               cmd_accept_r,
	output logic               cmd_ignored_r,
	output logic               polling_timeout_flag_r,
	output logic               data_indet_r,
	output logic               rwds_r,
	output logic [ECC_W-1:0]   ecc_unit_status,
	output logic [AW-1:0]      trap_addr,
	output logic               trap_valid,
	output logic               int_n
);

	fesr_main_st_t st_r;
	fesr_main_st_t st_nxt;

	logic prot_start;
	logic prot_done;
	logic ovl_exit;
	logic unit_rd;
	logic stall;

	// Where the device lands once an error is cleared
	function automatic fesr_mode_t ret_mode(input logic ovl, input logic esusp);
		fesr_mode_t m;
		m = MODE_READ;
		if (ovl)
		begin
			m = MODE_OVERLAY;
		end
		else if (esusp)
		begin
			m = MODE_ERASE_SUSP;
		end
		return m;
	endfunction

	// Reset command effects shared by every state that accepts it
	function automatic fesr_main_st_t sw_reset(input fesr_main_st_t s);
		fesr_main_st_t r;
		r = s;
		r.ovl     = 1'b0;
		r.ecc_ovl = 1'b0;
		r.poll_to = 1'b0;
		r.sr[SR_CLR_HI:SR_CLR_LO] = '0;
		r.eac     = EAC_STANDBY;
		return r;
	endfunction

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.accept = 1'b0;
		st_nxt.ignore = 1'b0;
		prot_start = 1'b0;
		ovl_exit   = 1'b0;
		unit_rd    = 1'b0;

		// Pin synchroniser; only the second stage is looked at
		st_nxt.cs_m = cs_n_pin;
		st_nxt.cs_s = st_r.cs_m;

		st_nxt.rwds  = rwds_in & ~stall;
		st_nxt.indet = rd_active & ~rd_is_status & (st_r.eac != EAC_STANDBY);

		if (timeout_evt)
		begin
			st_nxt.poll_to = 1'b1;
		end
		st_nxt.sr[SR_ESUSP] = erase_susp;
		st_nxt.sr[SR_PSUSP] = 1'b0;

		case (st_r.eac)
			EAC_STANDBY:
			begin
				if (cmd_valid)
				begin
					st_nxt.accept = 1'b1;
					case (cmd)
						CMD_PROGRAM:
						begin
							st_nxt.sr[SR_PROG]  = 1'b0;
							st_nxt.sr[SR_READY] = 1'b0;
							st_nxt.eac = EAC_BUSY;
						end
						CMD_ERASE:
						begin
							st_nxt.sr[SR_ESUSP] = 1'b0;
							st_nxt.sr[SR_READY] = 1'b0;
							st_nxt.eac = EAC_BUSY;
						end
						CMD_RESET:
						begin
							ovl_exit = st_r.ecc_ovl;
							st_nxt = sw_reset(st_nxt);
						end
						CMD_STATUS_CLEAR:
						begin
							st_nxt.sr[SR_CLR_HI:SR_CLR_LO] = '0;
						end
						CMD_OVL_ENTER:
						begin
							st_nxt.ovl = 1'b1;
						end
						CMD_ECC_ENTER:
						begin
							st_nxt.ecc_ovl = 1'b1;
							st_nxt.ovl     = 1'b1;
						end
						CMD_ECC_READ:
						begin
							if (st_r.ecc_ovl)
							begin
								unit_rd = 1'b1;
							end
							else
							begin
								st_nxt.accept = 1'b0;
								st_nxt.ignore = 1'b1;
							end
						end
						default:
						begin
							st_nxt.accept = 1'b1;
						end
					endcase
				end
			end
			EAC_BUSY:
			begin
				if (cmd_valid)
				begin
					st_nxt.accept = (cmd == CMD_STATUS_READ);
					st_nxt.ignore = (cmd != CMD_STATUS_READ);
				end
				if (op_done)
				begin
					if (op_res.prot_hit)
					begin
						prot_start = 1'b1;
						st_nxt.eac = EAC_PROT_BUSY;
						st_nxt.sr[SR_ERASE] = op_res.erase_fail;
						st_nxt.sr[SR_PROG]  = op_res.program_fail | op_res.pw_fail;
						st_nxt.sr[SR_WBA]   = 1'b0;
						st_nxt.sr[SR_PROT]  = 1'b1;
					end
					else if (op_res.wba_fail)
					begin
						st_nxt.eac = EAC_WBA_HOLD;
						st_nxt.sr[SR_READY] = 1'b1;
						st_nxt.sr[SR_ERASE] = 1'b0;
						st_nxt.sr[SR_PROG]  = 1'b1;
						st_nxt.sr[SR_WBA]   = 1'b1;
						st_nxt.sr[SR_PROT]  = 1'b0;
					end
					else if (op_res.erase_fail || op_res.blank_fail ||
						op_res.program_fail || op_res.pw_fail)
					begin
						st_nxt.eac = EAC_ERR_HOLD;
						st_nxt.sr[SR_READY] = 1'b1;
						st_nxt.sr[SR_ERASE] = op_res.erase_fail | op_res.blank_fail;
						st_nxt.sr[SR_PROG]  = op_res.program_fail | op_res.pw_fail;
						st_nxt.sr[SR_PROT]  = 1'b0;
					end
					else
					begin
						st_nxt.eac = EAC_STANDBY;
						st_nxt.sr[SR_READY] = 1'b1;
					end
				end
			end
			EAC_ERR_HOLD:
			begin
				if (cmd_valid)
				begin
					case (cmd)
						CMD_STATUS_READ:
						begin
							st_nxt.accept = 1'b1;
						end
						CMD_RESET:
						begin
							st_nxt.accept = 1'b1;
							ovl_exit = st_r.ecc_ovl;
							st_nxt = sw_reset(st_nxt);
						end
						CMD_STATUS_CLEAR:
						begin
							st_nxt.accept = 1'b1;
							st_nxt.sr[SR_CLR_HI:SR_CLR_LO] = '0;
							st_nxt.eac = EAC_STANDBY;
						end
						default:
						begin
							st_nxt.ignore = 1'b1;
						end
					endcase
				end
			end
			EAC_PROT_BUSY:
			begin
				if (cmd_valid)
				begin
					st_nxt.accept = (cmd == CMD_STATUS_READ);
					st_nxt.ignore = (cmd != CMD_STATUS_READ);
				end
				if (prot_done)
				begin
					st_nxt.sr[SR_READY] = 1'b1;
					st_nxt.eac = EAC_STANDBY;
				end
			end
			EAC_WBA_HOLD:
			begin
				if (cmd_valid)
				begin
					case (cmd)
						CMD_STATUS_READ:
						begin
							st_nxt.accept = 1'b1;
						end
						CMD_WBA_RESET,
						CMD_STATUS_CLEAR:
						begin
							st_nxt.accept = 1'b1;
							st_nxt.sr[SR_CLR_HI:SR_CLR_LO] = '0;
							st_nxt.eac = EAC_STANDBY;
						end
						default:
						begin
							st_nxt.ignore = 1'b1;
						end
					endcase
				end
			end
			default:
			begin
				st_nxt.eac = EAC_STANDBY;
			end
		endcase

		// Protection busy and abort hold look busy to the host; error hold looks ready
		st_nxt.busy = (st_nxt.eac == EAC_BUSY) || (st_nxt.eac == EAC_PROT_BUSY) ||
			(st_nxt.eac == EAC_WBA_HOLD);
		st_nxt.mode = ret_mode(st_nxt.ovl, erase_susp);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st_r      <= '0;
			st_r.eac  <= EAC_STANDBY;
			st_r.mode <= MODE_READ;
			st_r.sr   <= SR_RESET;
			st_r.cs_m <= 1'b1;
			st_r.cs_s <= 1'b1;
		end
		else if (ce)
		begin
			st_r <= st_nxt;
		end
	end

	fesr_prot_timer #(
		.CYC (BUSY_CYC)
	) u_prot_timer (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.start (prot_start),
		.busy  (),
		.done  (prot_done)
	);

	fesr_ecc_track #(
		.AW (AW)
	) u_ecc_track (
		.clk        (clk),
		.rst_n      (rst_n),
		.ce         (ce),
		.evt        (ecc_evt),
		.hp_addr    (hp_addr),
		.unit_rd    (unit_rd),
		.ovl_exit   (ovl_exit),
		.cs_low     (~st_r.cs_s),
		.stall_ctl  (config_word[CFG_STALL]),
		.int_en     (int_en),
		.status     (ecc_unit_status),
		.trap_addr  (trap_addr),
		.trap_valid (trap_valid),
		.stall      (stall),
		.int_n      (int_n)
	);

	assign status_word_r          = st_r.sr;
	assign eac_state_r            = st_r.eac;
	assign mode_r                 = st_r.mode;
	assign busy_r                 = st_r.busy;
	assign cmd_accept_r           = st_r.accept;
	assign cmd_ignored_r          = st_r.ignore;
	assign polling_timeout_flag_r = st_r.poll_to;
	assign data_indet_r           = st_r.indet;
	assign rwds_r                 = st_r.rwds;

endmodule

// *** inc/fesr_pkg.sv ***
// Shared constants, commands, states and carrier types of the flash error status block
package fesr_pkg;

	// Timing
	localparam int CLK_MHZ       = 100;
	localparam int PROT_BUSY_US  = 20;
	localparam int PROT_BUSY_CYC = PROT_BUSY_US * CLK_MHZ;
	localparam int PROT_CNT_W    = $clog2(PROT_BUSY_CYC + 1);

	// Widths
	localparam int ADDR_W = 25;
	localparam int SR_W   = 8;
	localparam int ECC_W  = 16;

	// Status word field positions and reset value
	localparam int SR_READY = 7;
	localparam int SR_ESUSP = 6;
	localparam int SR_ERASE = 5;
	localparam int SR_PROG  = 4;
	localparam int SR_WBA   = 3;
	localparam int SR_PSUSP = 2;
	localparam int SR_PROT  = 1;
	localparam int SR_CLR_HI = 5;
	localparam int SR_CLR_LO = 1;
	localparam logic [SR_W-1:0] SR_RESET = 8'h80;

	// ECC unit status field positions and reset value
	localparam int ECC_OFF  = 0;
	localparam int ECC_DATA = 1;
	localparam int ECC_CODE = 2;
	localparam int ECC_CORR = 3;
	localparam int ECC_DET  = 4;
	localparam logic [ECC_W-1:0] ECC_RESET = 16'h0000;

	// Configuration word bit that controls the strobe stall (0 = stall enabled)
	localparam int CFG_STALL = 2;

	typedef enum logic [3:0] {
		CMD_NONE,
		CMD_STATUS_READ,
		CMD_RESET,
		CMD_STATUS_CLEAR,
		CMD_WBA_RESET,
		CMD_ECC_READ,
		CMD_PROGRAM,
		CMD_ERASE,
		CMD_OVL_ENTER,
		CMD_ECC_ENTER,
		CMD_OTHER
	} fesr_cmd_t;

	typedef enum logic [2:0] {
		EAC_STANDBY,
		EAC_BUSY,
		EAC_ERR_HOLD,
		EAC_PROT_BUSY,
		EAC_WBA_HOLD
	} fesr_eac_t;

	typedef enum logic [1:0] {
		MODE_READ,
		MODE_OVERLAY,
		MODE_ERASE_SUSP
	} fesr_mode_t;

	typedef struct packed {
		logic erase_fail;
		logic blank_fail;
		logic program_fail;
		logic pw_fail;
		logic wba_fail;
		logic prot_hit;
	} fesr_op_res_t;

	typedef struct packed {
		logic hp_valid;
		logic corr;
		logic det;
		logic unit_off;
		logic data_err;
		logic code_err;
	} fesr_ecc_evt_t;

	typedef struct packed {
		fesr_eac_t       eac;
		fesr_mode_t      mode;
		logic [SR_W-1:0] sr;
		logic            ovl;
		logic            ecc_ovl;
		logic            poll_to;
		logic            accept;
		logic            ignore;
		logic            busy;
		logic            indet;
		logic            rwds;
		logic            cs_m;
		logic            cs_s;
	} fesr_main_st_t;

	typedef struct packed {
		logic [PROT_CNT_W-1:0] cnt;
		logic                  run;
		logic                  done;
	} fesr_tmr_st_t;

endpackage
